// ---- src/sfh_defines.svh ----
`ifndef SFH_DEFINES_SVH
`define SFH_DEFINES_SVH

// ****************************************
// Array organisation
// ****************************************
`define SFH_PAGE_COUNT      4096
`define SFH_PAGE_BITS       12
`define SFH_PAGE_SIZE_BIN   256
`define SFH_PAGE_SIZE_STD   264
`define SFH_BUFFER_COUNT    2
`define SFH_SEC_USER_BYTES  64
`define SFH_SEC_ID_BYTES    64
`define SFH_SEC_TOTAL_BYTES 128

// ****************************************
// Serial framing
// ****************************************
`define SFH_OPCODE_BITS     8
`define SFH_ADDR_BYTES      3
`define SFH_SCK_MAX_MHZ     66

// ****************************************
// Timing
// ****************************************
`define SFH_CLK_MHZ         125
`define SFH_PROG_TIME_US    4000
`define SFH_PROG_CYCLES     (`SFH_PROG_TIME_US * `SFH_CLK_MHZ)

`endif

// ---- src/sfh_frontend.sv ----
`timescale 1ns/1ps
`include "sfh_defines.svh"

module sfh_frontend
	import sfh_pkg::*;
#(
	parameter int unsigned PROG_CYCLES = `SFH_PROG_CYCLES
) (
	input  wire logic                  i_core_clk,
	input  wire logic                  i_resetn,
	input  wire logic                  i_cs_n,
	input  wire logic                  i_sck,
	input  wire logic                  i_si,
	input  wire logic                  i_reset_pin_n,
	input  wire logic                  i_page_264,
	input  wire logic                  i_sec_access,
	input  wire logic [7:0]            i_tx_byte,
	input  wire logic                  i_timed_req,
	output logic                       o_so,
	output logic                       o_so_oe,
	output sfh_pkg::sfh_rx_type        o_rx,
	output sfh_pkg::sfh_addr_type      o_addr,
	output logic                       o_selected,
	output logic                       o_busy,
	output logic                       o_standby
);
	import sfh_pkg::*;

	if (PROG_CYCLES < 1) begin : g_bad_cycles
		$error("PROG_CYCLES must be at least one");
	end

	// ****************************************
	// Pin synchronisers
	// ****************************************
	logic [3:0] pins_s;
	logic       cs_s;
	logic       sck_s;
	logic       si_s;
	logic       rst_pin_s;

	sfh_sync #(
		.W   (4),
		.RST (4'hD)
	) u_sync (
		.i_core_clk (i_core_clk),
		.i_resetn   (i_resetn),
		.i_async    ({i_cs_n, i_reset_pin_n, i_sck, i_si}),
		.o_sync     (pins_s)
	);

	assign cs_s      = pins_s[3];
	assign rst_pin_s = pins_s[2];
	assign sck_s     = pins_s[1];
	assign si_s      = pins_s[0];

	// ****************************************
	// Address split
	// ****************************************
	function automatic sfh_addr_type split_addr(input logic [23:0] a, input logic p264,
		input logic sec);
		sfh_addr_type r;
		r = '0;
		if (sec) begin
			r.offset = {2'h0, a[6:0]};
			r.sec_id = a[6];
		end else if (p264) begin
			r.page   = a[20:9];
			r.offset = a[8:0];
		end else begin
			r.page   = a[19:8];
			r.offset = {1'h0, a[7:0]};
		end
		return r;
	endfunction

	// ****************************************
	// State
	// ****************************************
	sfh_state_type s;
	sfh_state_type next_s;
	logic          rise;
	logic          fall;
	logic          cs_fall;
	logic          cs_rise;
	logic [31:0]   last_tick;

	assign rise      = sck_s & ~s.sck_q;
	assign fall      = ~sck_s & s.sck_q;
	assign cs_fall   = ~cs_s & s.cs_q;
	assign cs_rise   = cs_s & ~s.cs_q;
	assign last_tick = 32'(PROG_CYCLES - 1);

	always_comb begin
		next_s          = s;
		next_s.cs_q     = cs_s;
		next_s.sck_q    = sck_s;
		next_s.rx.valid = 1'h0;
		if (!rst_pin_s) begin
			next_s.sel       = 1'h0;
			next_s.so_oe     = 1'h0;
			next_s.busy      = 1'h0;
			next_s.arm       = 1'h0;
			next_s.timer     = 32'h0;
			next_s.seen_rise = 1'h0;
		end else begin
			if (cs_fall) begin
				next_s.sel       = 1'h1;
				next_s.seen_rise = 1'h0;
				next_s.bit_cnt   = 3'h0;
				next_s.byte_cnt  = 16'h0;
				next_s.tx_sh     = i_tx_byte;
				next_s.so        = i_tx_byte[7];
				next_s.so_oe     = 1'h1;
			end else if (cs_rise) begin
				next_s.sel   = 1'h0;
				next_s.so_oe = 1'h0;
				next_s.arm   = 1'h0;
				// A request in the closing cycle still counts: set wins over clear
				if ((s.arm || i_timed_req) && !s.busy) begin
					next_s.busy  = 1'h1;
					next_s.timer = 32'h0;
				end
			end else if (s.sel) begin
				// Mode 3 idles high, so a fall before the first rise is not a bit
				if (fall && s.seen_rise) begin
					if (s.bit_cnt == 3'h0) begin
						next_s.tx_sh = i_tx_byte;
						next_s.so    = i_tx_byte[7];
					end else begin
						next_s.tx_sh = {s.tx_sh[6:0], 1'h0};
						next_s.so    = s.tx_sh[6];
					end
				end
				if (rise) begin
					next_s.seen_rise = 1'h1;
					next_s.rx_sh     = {s.rx_sh[6:0], si_s};
					next_s.bit_cnt   = s.bit_cnt + 3'h1;
					if (s.bit_cnt == 3'h7) begin
						// Data keeps flowing while a page programs
						next_s.rx.valid     = 1'h1;
						next_s.rx.data      = {s.rx_sh[6:0], si_s};
						next_s.rx.is_opcode = (s.byte_cnt == 16'h0);
						next_s.rx.index     = s.byte_cnt;
						if (s.byte_cnt != 16'hFFFF) begin
							next_s.byte_cnt = s.byte_cnt + 16'h1;
						end
						if (s.byte_cnt != 16'h0 && s.byte_cnt <= 16'(`SFH_ADDR_BYTES)) begin
							next_s.addr_sh = {s.addr_sh[15:0], s.rx_sh[6:0], si_s};
						end
						if (s.byte_cnt == 16'(`SFH_ADDR_BYTES)) begin
							next_s.addr = split_addr({s.addr_sh[15:0], s.rx_sh[6:0], si_s},
								i_page_264, i_sec_access);
						end
					end
				end
				if (i_timed_req) begin
					next_s.arm = 1'h1;
				end
			end
			// Self-timed; the host only starts it, or aborts it with the reset pin
			if (s.busy) begin
				if (s.timer >= last_tick) begin
					next_s.busy  = 1'h0;
					next_s.timer = 32'h0;
				end else begin
					next_s.timer = s.timer + 32'h1;
				end
			end
		end
		next_s.standby = ~next_s.sel & ~next_s.busy;
	end

	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			s         <= '0;
			s.cs_q    <= 1'h1;
			s.standby <= 1'h1;
		end else begin
			s <= next_s;
		end
	end

	assign o_so       = s.so;
	assign o_so_oe    = s.so_oe;
	assign o_rx       = s.rx;
	assign o_addr     = s.addr;
	assign o_selected = s.sel;
	assign o_busy     = s.busy;
	assign o_standby  = s.standby;

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_resetn);

	a_deselect_hiz: assert property (
		cs_rise |=> !o_so_oe && !o_selected)
		else $error("output still driven after deselect");

	a_idle_no_rx: assert property (
		!s.sel |=> !o_rx.valid)
		else $error("byte taken while deselected");

	a_frame_start: assert property (
		cs_fall && rst_pin_s |=> o_selected && s.bit_cnt == 3'h0 && s.byte_cnt == 16'h0)
		else $error("counters not cleared at frame start");

	a_timed_hold: assert property (
		o_busy |-> !o_standby)
		else $error("standby entered during timed operation");

	a_rise_capture: assert property (
		o_rx.valid |-> $past(rise) && o_rx.data == {$past(s.rx_sh[6:0]), $past(si_s)})
		else $error("byte not built from rising edge samples");

	a_so_on_fall: assert property (
		$changed(o_so) && $past(o_selected) && o_selected |-> $past(fall))
		else $error("output changed off a falling edge");

	a_timed_len: assert property (
		$fell(o_busy) && $past(rst_pin_s) |-> $past(s.timer) == last_tick)
		else $error("timed operation length wrong");

	a_reset_abort: assert property (
		!rst_pin_s |=> !o_busy && !o_selected && !o_so_oe)
		else $error("reset did not abort");

endmodule

// ---- src/sfh_pkg.sv ----
package sfh_pkg;

	// ****************************************
	// Carriers
	// ****************************************
	typedef struct packed {
		logic        valid;
		logic        is_opcode;
		logic [15:0] index;
		logic [7:0]  data;
	} sfh_rx_type;

	typedef struct packed {
		logic        sec_id;
		logic [11:0] page;
		logic [8:0]  offset;
	} sfh_addr_type;

	typedef struct packed {
		logic        cs_q;
		logic        sck_q;
		logic        sel;
		logic        seen_rise;
		logic [2:0]  bit_cnt;
		logic [15:0] byte_cnt;
		logic [7:0]  rx_sh;
		logic [23:0] addr_sh;
		logic [7:0]  tx_sh;
		logic        so;
		logic        so_oe;
		logic        arm;
		logic        busy;
		logic [31:0] timer;
		logic        standby;
		sfh_rx_type  rx;
		sfh_addr_type addr;
	} sfh_state_type;

endpackage

// ---- src/sfh_sync.sv ----
`timescale 1ns/1ps

module sfh_sync #(
	parameter int         W   = 1,
	parameter logic [W-1:0] RST = '0
) (
	input  wire logic         i_core_clk,
	input  wire logic         i_resetn,
	input  wire logic [W-1:0] i_async,
	output logic      [W-1:0] o_sync
);

	// First stage feeds only the second stage
	logic [W-1:0] meta;

	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			meta   <= RST;
			o_sync <= RST;
		end else begin
			meta   <= i_async;
			o_sync <= meta;
		end
	end

endmodule

// ---- verif/sfh_frontend_tb.sv ----
`timescale 1ns/1ps
module sfh_frontend_tb;
	import sfh_pkg::*;
	localparam int PROG = 20;
	logic         i_core_clk, i_resetn, i_reset_pin_n, i_page_264, i_sec_access, i_timed_req;
	logic [7:0]   i_tx_byte;
	logic         cs_n, sck, si, o_so, o_so_oe, o_selected, o_busy, o_standby;
	sfh_rx_type   o_rx;
	sfh_addr_type o_addr;
	logic [7:0]   exp_q[$];
	int           idx, n, err_count, comparisons;

	sfh_frontend #(.PROG_CYCLES(PROG)) i_sfh_frontend (.i_core_clk(i_core_clk),
		.i_resetn(i_resetn), .i_cs_n(cs_n), .i_sck(sck), .i_si(si),
		.i_reset_pin_n(i_reset_pin_n), .i_page_264(i_page_264), .i_sec_access(i_sec_access),
		.i_tx_byte(i_tx_byte), .i_timed_req(i_timed_req), .o_so(o_so), .o_so_oe(o_so_oe),
		.o_rx(o_rx), .o_addr(o_addr), .o_selected(o_selected), .o_busy(o_busy),
		.o_standby(o_standby));
	sfh_host_model i_sfh_host_model (.i_so(o_so), .i_so_oe(o_so_oe), .o_cs_n(cs_n),
		.o_sck(sck), .o_si(si));

	task automatic check(input string nm, input logic [23:0] e, input logic [23:0] g);
		comparisons++;
		if (g !== e) begin
			err_count++;
			$display("ERROR %s expected %0h seen %0h", nm, e, g);
		end
	endtask
	task automatic print_verdict();
		if (err_count == 0 && comparisons > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	function automatic sfh_addr_type exp_addr(logic [23:0] a, logic p, logic s);
		sfh_addr_type r;
		r = '0;
		if (s) begin
			r.sec_id = a[6];
			r.offset = {2'h0, a[6:0]};
		end else if (p) begin
			r.page = a[20:9];
			r.offset = a[8:0];
		end else begin
			r.page = a[19:8];
			r.offset = {1'h0, a[7:0]};
		end
		return r;
	endfunction
	// Sampled on the falling core edge, away from register updates
	always @(negedge i_core_clk) begin
		if (o_rx.valid === 1'b1) begin
			check("rx_expected", 24'h1, 24'(exp_q.size() != 0));
			check("rx_index", 24'(idx), 24'(o_rx.index));
			check("rx_is_opcode", 24'(idx == 0), 24'(o_rx.is_opcode));
			if (exp_q.size() != 0) check("rx_data", 24'(exp_q.pop_front()), 24'(o_rx.data));
			idx++;
		end
	end
	task automatic run_frame(input logic m3, input realtime h, input logic timed);
		logic [7:0]   q[$];
		sfh_addr_type ea;
		int           c;
		@(posedge i_core_clk);
		i_page_264 <= 1'($urandom);
		i_sec_access <= 1'($urandom);
		i_tx_byte <= 8'($urandom);
		n = 4 + $urandom % 4;
		for (int i = 0; i < n; i++) q.push_back(8'($urandom));
		exp_q = q;
		idx = 0;
		fork
			i_sfh_host_model.frame(m3, q, h);
			if (timed) begin
				wait (o_selected === 1'b1);
				@(posedge i_core_clk) i_timed_req <= 1'b1;
				@(posedge i_core_clk) i_timed_req <= 1'b0;
			end
		join
		ea = exp_addr({q[1], q[2], q[3]}, i_page_264, i_sec_access);
		if (timed) begin
			c = 0;
			while (o_busy !== 1'b1 && c < 10) begin
				@(negedge i_core_clk);
				c++;
			end
			check("standby_busy", 24'h0, 24'(o_standby));
			c = 0;
			while (o_busy === 1'b1 && c < 100) begin
				@(negedge i_core_clk);
				c++;
			end
			check("busy_len", 24'(PROG), 24'(c));
			check("standby_end", 24'h1, 24'(o_standby));
		end
		repeat (5) @(negedge i_core_clk);
		check("rx_total", 24'(n), 24'(idx));
		check("deselect", 24'h4, {21'h0, o_standby, o_selected, o_so_oe});
		check("addr_offset", 24'(ea.offset), 24'(o_addr.offset));
		if (i_sec_access) check("addr_sec_id", 24'(ea.sec_id), 24'(o_addr.sec_id));
		else check("addr_page", 24'(ea.page), 24'(o_addr.page));
		foreach (i_sfh_host_model.rx_q[i]) begin
			check("so_byte", 24'(i_tx_byte), 24'(i_sfh_host_model.rx_q[i]));
		end
	endtask
	initial begin
		i_core_clk = 1'b0;
		forever #4 i_core_clk = ~i_core_clk;
	end
	// Roughly three times the longest expected run
	initial begin
		#400000;
		err_count++;
		print_verdict();
	end
	initial begin
		{i_resetn, i_page_264, i_sec_access, i_timed_req, i_tx_byte} = '0;
		i_reset_pin_n = 1'b1;
		err_count = 0;
		comparisons = 0;
		idx = 0;
		void'($urandom(62230));
		repeat (2) @(posedge i_core_clk);
		i_resetn <= 1'b1;
		repeat (3) @(posedge i_core_clk);
		for (int k = 0; k < 8; k++) run_frame(k[0], 62.5 + (k / 2) * 40, k >= 6);
		exp_q.delete();
		idx = 0;
		i_sfh_host_model.idle_noise(40);
		repeat (5) @(negedge i_core_clk);
		check("noise_bytes", 24'h0, 24'(idx));
		check("noise_oe", 24'h0, 24'(o_so_oe));
		exp_q = {8'hA5, 8'h3C, 8'h0F, 8'hF0};
		idx = 0;
		fork
			i_sfh_host_model.frame(1'b1, exp_q, 62.5);
			begin
				wait (idx == 1);
				@(posedge i_core_clk) i_reset_pin_n <= 1'b0;
				repeat (4) @(negedge i_core_clk);
				check("abort", 24'h0, {22'h0, o_selected, o_so_oe});
			end
		join
		check("abort_bytes", 24'h1, 24'(idx));
		@(posedge i_core_clk) i_reset_pin_n <= 1'b1;
		repeat (4) @(posedge i_core_clk);
		run_frame(1'b0, 62.5, 1'b0);
		print_verdict();
	end
endmodule

// ---- verif/sfh_host_model.sv ----
`timescale 1ns/1ps
module sfh_host_model (
	input  wire logic i_so,
	input  wire logic i_so_oe,
	output logic      o_cs_n,
	output logic      o_sck,
	output logic      o_si
);
	logic       last_so;
	logic       so_wire;
	logic [7:0] rx_q[$];
	// Released line floats, so show the inverse of its last value
	assign so_wire = (i_so_oe === 1'b1) ? i_so : ~last_so;
	always @(i_so or i_so_oe) if (i_so_oe === 1'b1) last_so = i_so;
	initial begin
		o_cs_n = 1'b1;
		o_sck = 1'b0;
		o_si = 1'b0;
		last_so = 1'b0;
	end
	// Half period h of at least 62.5 ns keeps the link clock slow
	task automatic frame(input logic m3, input logic [7:0] q[$], input realtime h);
		logic [7:0] r;
		rx_q.delete();
		o_sck = m3;
		#(h) o_cs_n = 1'b0;
		foreach (q[i]) begin
			for (int b = 7; b >= 0; b--) begin
				#(h) o_sck = 1'b0;
				o_si = q[i][b];
				#(h) o_sck = 1'b1;
				r = {r[6:0], so_wire};
			end
			rx_q.push_back(r);
		end
		#(h) o_sck = m3;
		#(h) o_cs_n = 1'b1;
		o_si = ~o_si;
	endtask
	task automatic idle_noise(input int n);
		repeat (n) begin
			#(62.5) o_sck = ~o_sck;
			o_si = ~o_si;
		end
	endtask
endmodule
